// ===== bench/pgpc_pin_model.sv
/*
  Pin model: resolves the pad from device drive, external drive and pulls.
  Assumes pad_in is sampled by the device on hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module pgpc_pin_model (
  // Clock
  input wire logic hclk,
  // Device pad controls
  input wire pgpc_pkg::pgpc_pad_t pad,
  // External driver
  input wire logic ext_en,
  input wire logic ext_val,
  // Level seen by the device
  output logic pad_in
);
  import pgpc_pkg::*;
  logic tgl;
  logic lvl;
  // Floating pad toggles so that no stale level is seen
  assign lvl = pad.pad_oe ? pad.pad_out : ext_en ? ext_val :
    pad.pull_up_enable ? 1'b1 : pad.pull_down_enable ? 1'b0 : tgl;
  initial begin
    tgl = 1'b0;
    pad_in = 1'b0;
  end
  always @(posedge hclk) begin
    tgl <= ~tgl;
    pad_in <= lvl;
  end
endmodule // pgpc_pin_model
`default_nettype wire

// ===== bench/pgpc_top_props.sv
/*
  Checker on the pgpc_top ports, bound into the design.
  Assumes register writes land at the data-phase edge.
*/
`timescale 1ns/100ps
`default_nettype none
module pgpc_top_props #(
  parameter int TICK_CYCLES = 10
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pad and event
  input wire logic pad_in,
  input wire pgpc_pkg::pgpc_pad_t pad,
  input wire logic edge_event
);
  import pgpc_pkg::*;
  pgpc_config_t cfg_s;
  pgpc_config_t cp;
  logic alt_s, ap, wr_p, up, pin_q;
  logic [7:0] wa;
  logic [19:0] stab;
  logic [19:0] need;
  logic go_o;
  // Shadow of the configuration, delayed to change on the same edge as the pad update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_s <= '0;
      cp <= '0;
      alt_s <= 1'b0;
      ap <= 1'b0;
      wr_p <= 1'b0;
      wa <= 8'h00;
      up <= 1'b0;
      pin_q <= 1'b0;
      stab <= 20'h00000;
    end else begin
      wr_p <= hsel && hready && htrans[1] && hwrite;
      wa <= haddr[7:0];
      if (wr_p && wa == PGPC_CONFIG_OFFSET) cfg_s <= hwdata[7:0];
      if (wr_p && wa == PGPC_ALTCTL_OFFSET) alt_s <= hwdata[0];
      cp <= cfg_s;
      ap <= alt_s;
      up <= 1'b1;
      pin_q <= pad_in;
      stab <= (pad_in != pin_q) ? 20'h00000 : stab + 20'(stab != 20'hfffff);
    end
  end
  assign go_o = up && !ap && !cp.direction;
  assign need = (cp.debounce == PGPC_DBNC_NONE) ? 20'h00000 :
    20'((((PGPC_DBNC_8_MS << cp.debounce) >> 1) - 1) * TICK_CYCLES);
  sequence s_no_rd;
    !(hsel && hready && htrans[1] && !hwrite) ##1 1'b1;
  endsequence
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_ready_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_out_low: assert property (go_o && !cp.output_level |-> pad.pad_oe && !pad.pad_out)
    else $error("output low not driven");
  a_od_release: assert property (go_o && cp.output_level && !cp.drive_type |-> !pad.pad_oe)
    else $error("open drain high not released");
  a_pp_high: assert property (go_o && cp.output_level && cp.drive_type |-> pad.pad_oe && pad.pad_out)
    else $error("push pull high not driven");
  a_in_pull: assert property (up && !ap && cp.direction |-> !pad.pad_oe
    && pad.pull_up_enable != cp.output_level && pad.pull_down_enable == cp.output_level)
    else $error("input pull wrong");
  a_no_event_out: assert property ((!ap && !cp.direction) [*3] |-> !edge_event)
    else $error("edge event in output mode");
  a_event_masked: assert property ((cp.direction && cp.edge_irq == PGPC_IRQ_MASKED) [*3]
    |-> !edge_event)
    else $error("edge event while masked");
  a_dbnc_hold: assert property (edge_event && cp.direction |-> stab >= need)
    else $error("edge event before debounce time");
  a_hrdata_hold: assert property (s_no_rd |-> $stable(hrdata))
    else $error("read data changed without a read");
endmodule // pgpc_top_props
bind pgpc_top pgpc_top_props #(.TICK_CYCLES(TICK_CYCLES)) props_u (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .pad_in(pad_in), .pad(pad), .edge_event(edge_event));
`default_nettype wire

// ===== bench/pgpc_top_tb_top.sv
/*
  Self-checking bench for pgpc_top with a 10-cycle tick.
  Assumes the pin model resolves the pad level.
*/
`timescale 1ns/100ps
`default_nettype none
module pgpc_top_tb_top;
  import pgpc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic pad_in, alt_o, alt_in, edge_event, ext_en, ext_val;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  pgpc_pad_t pad;
  int n_mismatch, total_checks, n_ev, e, i, n;
  assign hready = hreadyout;
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  pgpc_top #(.TICK_CYCLES(10)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in),
    .pad(pad), .alt_out(alt_o), .alt_in(alt_in), .edge_event(edge_event));
  pgpc_pin_model pin_u (.hclk(hclk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in(pad_in));
  always @(posedge hclk) begin
    if (hresetn !== 1'b1) n_ev <= 0;
    else if (edge_event === 1'b1) n_ev <= n_ev + 1;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task rdy;
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    n_mismatch++;
    close_out();
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
    @(posedge hclk);
  endtask
  task t_reset;
    bus(0, PGPC_CONFIG_OFFSET, 0);
    chk(r, {24'h0, PGPC_CONFIG_RESET});
    bus(1, 8'hf0, 32'hffffffff);
    bus(0, 8'hf0, 0);
    chk(r, 32'h0);
  endtask
  task t_out;
    for (i = 0; i < 4; i++) begin
      bus(1, PGPC_CONFIG_OFFSET, {24'h0, 4'h3, i[1], 2'b00, i[0]});
      repeat (3) @(posedge hclk);
      chk(pad.pad_oe, !(i[1] && !i[0]));
      chk(pad.pad_out && pad.pad_oe, i[1] && i[0]);
      bus(0, PGPC_CONFIG_OFFSET, 0);
      chk(r & 32'hfb, {24'h0, 4'h3, i[1], 2'b00, i[0]});
    end
  endtask
  task t_in;
    bus(1, PGPC_CONFIG_OFFSET, 32'h02);
    repeat (4) @(posedge hclk);
    chk({pad.pull_up_enable, pad.pull_down_enable}, 2'b10);
    bus(0, PGPC_CONFIG_OFFSET, 0);
    chk(r & 32'h4, 32'h4);
    bus(1, PGPC_CONFIG_OFFSET, 32'h0e);
    repeat (4) @(posedge hclk);
    chk({pad.pull_up_enable, pad.pull_down_enable}, 2'b01);
    bus(0, PGPC_CONFIG_OFFSET, 0);
    chk(r & 32'h4, 32'h0);
    ext_en <= 1'b1;
    ext_val <= 1'b1;
    repeat (4) @(posedge hclk);
    bus(1, PGPC_CONFIG_OFFSET, 32'h0a);
    bus(0, PGPC_CONFIG_OFFSET, 0);
    chk(r & 32'h4, 32'h4);
  endtask
  task t_irq;
    for (i = 0; i < 4; i++) begin
      bus(1, PGPC_CONFIG_OFFSET, {24'h0, 2'b00, i[1:0], 4'h2});
      repeat (5) @(posedge hclk);
      e = n_ev;
      ext_val <= 1'b0;
      repeat (10) @(posedge hclk);
      chk(n_ev - e, i[0]);
      e = n_ev;
      ext_val <= 1'b1;
      repeat (10) @(posedge hclk);
      chk(n_ev - e, i[1]);
      bus(0, PGPC_STATUS_OFFSET, 0);
      chk(r, {30'h0, (i != 0), 1'b1});
    end
  endtask
  task t_dbnc;
    for (i = 1; i < 4; i++) begin
      bus(1, PGPC_CONFIG_OFFSET, {24'h0, i[1:0], 6'h32});
      n = 10 * (PGPC_DBNC_8_MS << (i - 1));
      e = n_ev;
      ext_val <= 1'b0;
      repeat (n - 15) @(posedge hclk);
      ext_val <= 1'b1;
      repeat (n + 20) @(posedge hclk);
      chk(n_ev - e, 0);
      ext_val <= 1'b0;
      repeat (n + 20) @(posedge hclk);
      chk(n_ev - e, 1);
      ext_val <= 1'b1;
      repeat (n + 20) @(posedge hclk);
      chk(n_ev - e, 2);
    end
  endtask
  task t_alt;
    bus(1, PGPC_ALTCTL_OFFSET, 32'h3);
    bus(1, PGPC_CONFIG_OFFSET, 32'h00);
    repeat (6) @(posedge hclk);
    chk(alt_in, 1'b0);
    bus(1, PGPC_CONFIG_OFFSET, 32'h02);
    repeat (6) @(posedge hclk);
    chk(alt_in, 1'b1);
    bus(1, PGPC_ALTCTL_OFFSET, 32'h1);
    bus(1, PGPC_CONFIG_OFFSET, 32'h01);
    alt_o <= 1'b1;
    repeat (4) @(posedge hclk);
    chk({pad.pad_oe, pad.pad_out}, 2'b11);
    alt_o <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({pad.pad_oe, pad.pad_out}, 2'b10);
    bus(1, PGPC_ALTCTL_OFFSET, 32'h0);
  endtask
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_en, ext_val, alt_o} = '0;
    {n_mismatch, total_checks} = '0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_irq();
    t_dbnc();
    t_alt();
    close_out();
  end
endmodule // pgpc_top_tb_top
`default_nettype wire

// ===== verilog/pgpc_debounce.sv
/*
  Debouncer: the output follows the input once it has stood stable for
  the selected number of millisecond ticks; zero ticks passes it through.
  Assumes the input is already synchronous to hclk.
*/
`timescale 1ns/100ps
`default_nettype none
module pgpc_debounce (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic tick,
  input wire logic [5:0] hold_ticks,
  // Signal
  input wire logic din,
  output logic dout
);
  import pgpc_pkg::*;

  logic [5:0] cnt_reg;
  wire logic differs = (din != dout);
  wire logic bypass = (hold_ticks == 6'h00);
  wire logic settled = differs && tick && (cnt_reg + 6'h01 >= hold_ticks);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 6'h00;
      dout <= 1'b0;
    end else if (!differs) begin
      cnt_reg <= 6'h00;
    end else if (bypass || settled) begin
      dout <= din;
      cnt_reg <= 6'h00;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 6'h01;
    end
  end
endmodule // pgpc_debounce
`default_nettype wire

// ===== verilog/pgpc_pkg.sv
/*
  Package for the GPIO pin configuration block: register map, field
  layout, reset values, debounce and interrupt encodings, timing counts.
  Assumes a 100 MHz hclk.
*/
`default_nettype none
package pgpc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PGPC_CONFIG_OFFSET = 8'h74;
  localparam logic [7:0] PGPC_STATUS_OFFSET = 8'h78;
  localparam logic [7:0] PGPC_ALTCTL_OFFSET = 8'h7c;
  localparam logic [7:0] PGPC_CONFIG_RESET = 8'h00;
  localparam logic [1:0] PGPC_ALTCTL_RESET = 2'h0;

  // ----------------------------------------------------------------
  // Field positions in the configuration register
  // ----------------------------------------------------------------
  localparam int PGPC_DRV_BIT = 0;
  localparam int PGPC_DIR_BIT = 1;
  localparam int PGPC_DI_BIT = 2;
  localparam int PGPC_DO_BIT = 3;
  localparam int PGPC_IRQ_LSB = 4;
  localparam int PGPC_DBNC_LSB = 6;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PGPC_DBNC_NONE = 2'b00,
    PGPC_DBNC_8MS = 2'b01,
    PGPC_DBNC_16MS = 2'b10,
    PGPC_DBNC_32MS = 2'b11
  } pgpc_dbnc_t;

  typedef enum logic [1:0] {
    PGPC_IRQ_MASKED = 2'b00,
    PGPC_IRQ_FALL = 2'b01,
    PGPC_IRQ_RISE = 2'b10,
    PGPC_IRQ_BOTH = 2'b11
  } pgpc_irq_t;

  typedef struct packed {
    pgpc_dbnc_t debounce;
    pgpc_irq_t edge_irq;
    logic output_level;
    logic input_level;
    logic direction;
    logic drive_type;
  } pgpc_config_t;

  // Pin pad controls
  typedef struct packed {
    logic pad_out;
    logic pad_oe;
    logic pull_up_enable;
    logic pull_down_enable;
  } pgpc_pad_t;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int PGPC_CLK_MHZ = 100;
  localparam int PGPC_TICK_US = 1000;
  localparam int PGPC_TICK_CYCLES = PGPC_TICK_US * PGPC_CLK_MHZ;
  localparam int PGPC_DBNC_8_MS = 8;
  localparam int PGPC_DBNC_16_MS = 16;
  localparam int PGPC_DBNC_32_MS = 32;

endpackage
`default_nettype wire

// ===== verilog/pgpc_tick.sv
/*
  One-cycle enable pulse every TICK_CYCLES clocks (1 ms by default).
  Assumes a single clock domain with asynchronous active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module pgpc_tick #(
  parameter int TICK_CYCLES = 100000
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Tick
  output logic tick
);
  import pgpc_pkg::*;

  logic [23:0] cnt_reg;
  wire logic wrap = (cnt_reg == 24'(TICK_CYCLES - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= 24'h000000;
      tick <= 1'b0;
    end else begin
      cnt_reg <= wrap ? 24'h000000 : cnt_reg + 24'h000001;
      tick <= wrap;
    end
  end
endmodule // pgpc_tick
`default_nettype wire

// ===== verilog/pgpc_top.sv
/*
  GPIO pin configuration block with an AHB-Lite register slave.
  Holds the pin configuration register, drives the pad, debounces the
  input, reports its level and raises an edge event pulse.
  Assumes the pad input is synchronous to hclk and a single AHB master.
*/
// Local design decision: the AHB-Lite slave port.
// Operation
// - Input mode debounces both edges for none, 8, 16 or 32 ms.
// - Input mode edge event: masked, falling, rising or both edges.
// - Output low on level 0; on 1 drive high or release per type.
// - Input mode: level bit 0 pull-up, 1 pull-down.
// - Output mode: drive-type 0 open-drain, 1 push-pull.
// - Alternate input: direction bit sets polarity, 0 active-low.
// - Input mode: input level bit reports sampled pin level.
// - Alternate off: direction 0 output, 1 input.
// - Input mode: writes to input level bit are discarded.
`timescale 1ns/100ps
`default_nettype none
module pgpc_top #(
  parameter int TICK_CYCLES = pgpc_pkg::PGPC_TICK_CYCLES
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pad
  input wire logic pad_in,
  output var pgpc_pkg::pgpc_pad_t pad,
  // Alternate function
  input wire logic alt_out,
  output logic alt_in,
  // Edge event
  output logic edge_event
);
  import pgpc_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [5:0] dbnc_ticks(input pgpc_dbnc_t sel);
    unique case (sel)
      PGPC_DBNC_NONE: dbnc_ticks = 6'h00;
      PGPC_DBNC_8MS: dbnc_ticks = 6'(PGPC_DBNC_8_MS);
      PGPC_DBNC_16MS: dbnc_ticks = 6'(PGPC_DBNC_16_MS);
      PGPC_DBNC_32MS: dbnc_ticks = 6'(PGPC_DBNC_32_MS);
    endcase
  endfunction

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] off);
    addr_hit = (a[7:2] == off[7:2]);
  endfunction

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  pgpc_config_t cfg_reg;
  logic [1:0] alt_reg;
  logic wr_pend_reg;
  logic [7:0] addr_reg;
  logic event_seen_reg;

  wire logic take = hsel && hready && htrans[1];
  wire logic wr_cfg = wr_pend_reg && addr_hit(addr_reg, PGPC_CONFIG_OFFSET);
  wire logic wr_alt = wr_pend_reg && addr_hit(addr_reg, PGPC_ALTCTL_OFFSET);
  wire logic rd_status = take && !hwrite && addr_hit(haddr[7:0], PGPC_STATUS_OFFSET);
  wire logic [3:0] wstrb = 4'h1 << haddr[1:0];

  // Alternate control: bit 0 enables alternate mode, bit 1 picks input use
  wire logic alt_en = alt_reg[0];
  wire logic alt_as_input = alt_reg[1];
  wire logic is_input = cfg_reg.direction && !alt_en;
  wire logic is_output = !cfg_reg.direction && !alt_en;

  // ----------------------------------------------------------------
  // Input path
  // ----------------------------------------------------------------
  logic tick;
  logic db_level;
  logic db_prev_reg;

  pgpc_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick)
  );

  pgpc_debounce u_dbnc (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(tick),
    .hold_ticks(is_input ? dbnc_ticks(cfg_reg.debounce) : 6'h00),
    .din(pad_in),
    .dout(db_level)
  );

  wire logic rise = db_level && !db_prev_reg;
  wire logic fall = !db_level && db_prev_reg;
  wire logic edge_hit = is_input && (
    (cfg_reg.edge_irq == PGPC_IRQ_FALL && fall) ||
    (cfg_reg.edge_irq == PGPC_IRQ_RISE && rise) ||
    (cfg_reg.edge_irq == PGPC_IRQ_BOTH && (rise || fall)));

  // ----------------------------------------------------------------
  // Register write data
  // ----------------------------------------------------------------
  logic [7:0] wbyte;
  pgpc_config_t cfg_next;
  assign wbyte = hwdata[7:0];
  assign cfg_next = wr_cfg ? pgpc_config_t'({wbyte[7:3],
    (cfg_reg.direction ? db_level : wbyte[2]),
    wbyte[1:0]}) : pgpc_config_t'({cfg_reg[7:3],
    (is_input ? db_level : cfg_reg.input_level), cfg_reg[1:0]});

  // Pad controls
  pgpc_pad_t pad_next;
  wire logic drv_level = alt_en ? alt_out : cfg_reg.output_level;
  wire logic drives = !alt_en ? is_output : !alt_as_input;
  assign pad_next.pad_out = drv_level;
  assign pad_next.pad_oe = drives && (!drv_level || cfg_reg.drive_type);
  assign pad_next.pull_up_enable = is_input && !cfg_reg.output_level;
  assign pad_next.pull_down_enable = is_input && cfg_reg.output_level;

  wire logic alt_in_next = cfg_reg.direction ? db_level : !db_level;

  logic [31:0] rdata_next;
  assign rdata_next = addr_hit(haddr[7:0], PGPC_CONFIG_OFFSET) ? {24'h000000, cfg_next} :
    addr_hit(haddr[7:0], PGPC_STATUS_OFFSET) ? {30'h00000000, edge_hit | event_seen_reg, db_level} :
    addr_hit(haddr[7:0], PGPC_ALTCTL_OFFSET) ? {30'h00000000, alt_reg} : 32'h00000000;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      wr_pend_reg <= take && hwrite && wstrb[0];
      if (take) begin
        addr_reg <= haddr[7:0];
      end
      if (take && !hwrite) begin
        hrdata <= rdata_next;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= pgpc_config_t'(PGPC_CONFIG_RESET);
      alt_reg <= PGPC_ALTCTL_RESET;
      db_prev_reg <= 1'b0;
      event_seen_reg <= 1'b0;
      pad <= '0;
      alt_in <= 1'b0;
      edge_event <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      if (wr_alt) begin
        alt_reg <= hwdata[1:0];
      end
      db_prev_reg <= db_level;
      // Set wins over read-clear
      event_seen_reg <= edge_hit || (event_seen_reg && !rd_status);
      pad <= pad_next;
      alt_in <= alt_in_next;
      edge_event <= edge_hit;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule // pgpc_top
`default_nettype wire
